// ---- rtcam_pkg.sv ----
/*
 * shared constants and carrier types of the dual alarm-match block.
 * assumes a serial front end that turns bus traffic into byte register accesses.
 */
package rtcam_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses of the serial register map)
   // ---------------------------------------------------------------
   localparam logic [7:0] RTCAM_OFS_ALM1_SEC  = 8'h07;
   localparam logic [7:0] RTCAM_OFS_ALM1_LAST = 8'h0A;
   localparam logic [7:0] RTCAM_OFS_ALM2_MIN  = 8'h0B;
   localparam logic [7:0] RTCAM_OFS_ALM2_LAST = 8'h0D;
   localparam logic [7:0] RTCAM_OFS_CONTROL   = 8'h0E;
   localparam logic [7:0] RTCAM_OFS_STATUS    = 8'h0F;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int         RTCAM_MASK_BIT      = 7;
   localparam int         RTCAM_DYDT_BIT      = 6;
   localparam int         RTCAM_IRQ_MODE_BIT  = 2;
   localparam int         RTCAM_ALM2_IE_BIT   = 1;
   localparam int         RTCAM_ALM1_IE_BIT   = 0;
   localparam int         RTCAM_ALM2_FLAG_BIT = 1;
   localparam int         RTCAM_ALM1_FLAG_BIT = 0;
   localparam logic [7:0] RTCAM_CONTROL_RST   = 8'h1C;
   localparam logic [7:0] RTCAM_ALARM_RST     = 8'h00;
   localparam logic [7:0] RTCAM_UNMAPPED_RD   = 8'h00;
   localparam logic [6:0] RTCAM_ZERO_SECONDS  = 7'h00;

   // ---------------------------------------------------------------
   // carrier types
   // ---------------------------------------------------------------
   // current timekeeping values, packed decimal digits
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] day;
      logic [7:0] date;
   } rtcam_time_type;

   // byte register access from the serial front end
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rtcam_regacc_type;

   typedef struct packed {
      logic [3:0][7:0] alm1;
      logic [2:0][7:0] alm2;
      logic [7:0]      control;
      logic [1:0]      flags;
      logic [7:0]      rdata;
      logic            irq_n;
   } rtcam_state_type;

endpackage : rtcam_pkg

// ---- rtcam_field_cmp.sv ----
/*
 * one masked packed-decimal field compare of an alarm.
 * assumes both values are already aligned to the low bits.
 */
`timescale 1ns/100ps
`default_nettype none

module rtcam_field_cmp
   import rtcam_pkg::*;
#(
   parameter int W = 7
)
(
   // compare inputs
   input  wire logic         i_mask,
   input  wire logic [W-1:0] i_stored,
   input  wire logic [W-1:0] i_current,
   // result
   output logic              o_match
);

   // a set mask drops the field from the compare
   assign o_match = i_mask | (i_stored == i_current); // RL3 RL14

endmodule // rtcam_field_cmp

`default_nettype wire

// ---- rtcam_alarm.sv ----
/*
 * dual alarm-match logic of a real-time clock: alarm registers, control
 * register, alarm flags and the active-low interrupt output.
 * assumes the serial front end delivers one-cycle byte accesses and that the
 * timekeeping block pulses i_tick_update while i_time already shows the new time.
 */
// Function
// [RL1] Alarm one keeps its seconds, minutes, hours and day/date bytes at offsets 07h to 0Ah, written by the host.
// [RL2] Alarm two keeps minutes, hours and day/date bytes at offsets 0Bh to 0Dh and has no seconds field.
// [RL3] Bit 7 of every alarm byte is a mask that removes that field from the compare.
// [RL4] With all masks of an alarm clear, it fires only when every stored field equals the current time.
// [RL5] With the day/date select bit 6 at zero the low six bits are compared with the month date.
// [RL6] With the day/date select bit at one the low six bits are compared with the weekday.
// [RL7] A match sets that alarm's flag whether or not its interrupt is enabled.
// [RL8] The interrupt output is active only while flag, that alarm's enable and the mode select are all one.
// [RL9] Matches are evaluated only at the once-per-second update, never at writes.
// [RL10] Alarm one masks give every second, seconds match, minutes+seconds, adding hours, adding day/date.
// [RL11] Alarm two masks give each minute at zero seconds, minutes match, hours+minutes, adding day/date.
// [RL12] The host programs only the listed mask patterns; other patterns are undefined.
// [RL13] Control bit 2 is the mode select, bit 1 alarm two enable, bit 0 alarm one enable; reset gives 1, 0, 0.
// [RL14] Time and alarm values are packed decimal and compared digit field by digit field.
// [RL15] A flag stays set until the host writes zero to it, then the interrupt output releases.
`timescale 1ns/100ps
`default_nettype none

module rtcam_alarm
   import rtcam_pkg::*;
(
   // clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_nrst,
   // register access from the serial front end
   input  wire rtcam_regacc_type i_reg,
   // timekeeping
   input  wire logic             i_tick_update,
   input  wire rtcam_time_type   i_time,
   // outputs
   output logic [7:0]            o_reg_rdata,
   output logic [1:0]            o_alarm_flags,
   output logic                  o_irq_or_square_wave_out_n
);

   rtcam_state_type st_r;
   rtcam_state_type st_nxt;

   // ---------------------------------------------------------------
   // field compares
   // ---------------------------------------------------------------
   logic [3:0] a1_hit;
   logic [2:0] a2_hit;
   logic [5:0] a1_dd_cur;
   logic [5:0] a2_dd_cur;
   logic       a2_on_minute;
   logic       match1;
   logic       match2;

   // weekday or month date chosen per alarm
   assign a1_dd_cur = st_r.alm1[3][RTCAM_DYDT_BIT] ? i_time.day[5:0] : i_time.date[5:0]; // RL5 RL6
   assign a2_dd_cur = st_r.alm2[2][RTCAM_DYDT_BIT] ? i_time.day[5:0] : i_time.date[5:0]; // RL5 RL6

   rtcam_field_cmp #(.W(7)) u_a1_sec
   (
      .i_mask    (st_r.alm1[0][RTCAM_MASK_BIT]),
      .i_stored  (st_r.alm1[0][6:0]),
      .i_current (i_time.sec[6:0]),
      .o_match   (a1_hit[0])
   );
   rtcam_field_cmp #(.W(7)) u_a1_min
   (
      .i_mask    (st_r.alm1[1][RTCAM_MASK_BIT]),
      .i_stored  (st_r.alm1[1][6:0]),
      .i_current (i_time.min[6:0]),
      .o_match   (a1_hit[1])
   );
   rtcam_field_cmp #(.W(7)) u_a1_hour
   (
      .i_mask    (st_r.alm1[2][RTCAM_MASK_BIT]),
      .i_stored  (st_r.alm1[2][6:0]),
      .i_current (i_time.hour[6:0]),
      .o_match   (a1_hit[2])
   );
   rtcam_field_cmp #(.W(6)) u_a1_dd
   (
      .i_mask    (st_r.alm1[3][RTCAM_MASK_BIT]),
      .i_stored  (st_r.alm1[3][5:0]),
      .i_current (a1_dd_cur),
      .o_match   (a1_hit[3])
   );
   rtcam_field_cmp #(.W(7)) u_a2_min
   (
      .i_mask    (st_r.alm2[0][RTCAM_MASK_BIT]),
      .i_stored  (st_r.alm2[0][6:0]),
      .i_current (i_time.min[6:0]),
      .o_match   (a2_hit[0])
   );
   rtcam_field_cmp #(.W(7)) u_a2_hour
   (
      .i_mask    (st_r.alm2[1][RTCAM_MASK_BIT]),
      .i_stored  (st_r.alm2[1][6:0]),
      .i_current (i_time.hour[6:0]),
      .o_match   (a2_hit[1])
   );
   rtcam_field_cmp #(.W(6)) u_a2_dd
   (
      .i_mask    (st_r.alm2[2][RTCAM_MASK_BIT]),
      .i_stored  (st_r.alm2[2][5:0]),
      .i_current (a2_dd_cur),
      .o_match   (a2_hit[2])
   );

   // masks only widen the compare; undefined mask mixes are not trapped
   assign match1       = &a1_hit; // RL4 RL10 RL12
   // alarm two has no seconds byte, so it always waits for the zero second
   assign a2_on_minute = (i_time.sec[6:0] == RTCAM_ZERO_SECONDS);
   assign match2       = (&a2_hit) & a2_on_minute; // RL11

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic [1:0] set_flags;
   logic [1:0] clr_flags;
   logic       irq_active;

   always_comb
   begin
      st_nxt    = st_r;
      set_flags = 2'h0;
      clr_flags = 2'h0;

      if (i_reg.wr)
      begin
         if (i_reg.addr >= RTCAM_OFS_ALM1_SEC && i_reg.addr <= RTCAM_OFS_ALM1_LAST)
            st_nxt.alm1[2'(i_reg.addr - RTCAM_OFS_ALM1_SEC)] = i_reg.wdata; // RL1
         else if (i_reg.addr >= RTCAM_OFS_ALM2_MIN && i_reg.addr <= RTCAM_OFS_ALM2_LAST)
            st_nxt.alm2[2'(i_reg.addr - RTCAM_OFS_ALM2_MIN)] = i_reg.wdata; // RL2
         else if (i_reg.addr == RTCAM_OFS_CONTROL)
            st_nxt.control = i_reg.wdata; // RL13
         else if (i_reg.addr == RTCAM_OFS_STATUS)
            clr_flags = ~i_reg.wdata[1:0]; // RL15
      end

      // compare only at the second update; writes alone never fire an alarm
      if (i_tick_update)
      begin
         set_flags[RTCAM_ALM1_FLAG_BIT] = match1; // RL9 RL7
         set_flags[RTCAM_ALM2_FLAG_BIT] = match2; // RL9 RL7
      end
      // a match in the cycle of the clearing write is kept
      st_nxt.flags = (st_r.flags & ~clr_flags) | set_flags; // RL15 RL7

      if (i_reg.rd)
      begin
         if (i_reg.addr >= RTCAM_OFS_ALM1_SEC && i_reg.addr <= RTCAM_OFS_ALM1_LAST)
            st_nxt.rdata = st_r.alm1[2'(i_reg.addr - RTCAM_OFS_ALM1_SEC)];
         else if (i_reg.addr >= RTCAM_OFS_ALM2_MIN && i_reg.addr <= RTCAM_OFS_ALM2_LAST)
            st_nxt.rdata = st_r.alm2[2'(i_reg.addr - RTCAM_OFS_ALM2_MIN)];
         else if (i_reg.addr == RTCAM_OFS_CONTROL)
            st_nxt.rdata = st_r.control;
         else if (i_reg.addr == RTCAM_OFS_STATUS)
            st_nxt.rdata = {6'h00, st_r.flags};
         else
            st_nxt.rdata = RTCAM_UNMAPPED_RD;
      end

      // in square-wave mode the alarm path leaves the pin released
      irq_active = st_r.control[RTCAM_IRQ_MODE_BIT] &
                   ((st_r.flags[RTCAM_ALM1_FLAG_BIT] & st_r.control[RTCAM_ALM1_IE_BIT]) |
                    (st_r.flags[RTCAM_ALM2_FLAG_BIT] & st_r.control[RTCAM_ALM2_IE_BIT])); // RL8
      st_nxt.irq_n = ~irq_active; // RL8 RL15
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         st_r.alm1    <= {4{RTCAM_ALARM_RST}};
         st_r.alm2    <= {3{RTCAM_ALARM_RST}};
         st_r.control <= RTCAM_CONTROL_RST; // RL13
         st_r.flags   <= 2'h0;
         st_r.rdata   <= RTCAM_UNMAPPED_RD;
         st_r.irq_n   <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign o_reg_rdata                = st_r.rdata;
   assign o_alarm_flags              = st_r.flags;
   assign o_irq_or_square_wave_out_n = st_r.irq_n;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   AST_ALM1_WRITE: assert property (i_reg.wr && i_reg.addr == RTCAM_OFS_ALM1_LAST |=> // RL1
      st_r.alm1[3] == $past(i_reg.wdata)) else $error("alarm one day byte not stored");
   AST_ALM2_WRITE: assert property (i_reg.wr && i_reg.addr == RTCAM_OFS_ALM2_MIN |=> // RL2
      st_r.alm2[0] == $past(i_reg.wdata)) else $error("alarm two minute byte not stored");
   AST_CTRL_WRITE: assert property (i_reg.wr && i_reg.addr == RTCAM_OFS_CONTROL |=> // RL13
      st_r.control == $past(i_reg.wdata)) else $error("control byte not stored");
   AST_EXACT_SEC: assert property (i_tick_update && !st_r.alm1[0][RTCAM_MASK_BIT] && // RL4
      st_r.alm1[0][6:0] != i_time.sec[6:0] && !st_r.flags[0] && !i_reg.wr |=> !st_r.flags[0])
      else $error("alarm one fired with seconds mismatch");
   AST_WEEKDAY: assert property (i_tick_update && st_r.alm1[3][RTCAM_DYDT_BIT] && // RL6
      !st_r.alm1[3][RTCAM_MASK_BIT] && st_r.alm1[3][5:0] != i_time.day[5:0] && !st_r.flags[0]
      |=> !st_r.flags[0]) else $error("alarm one fired with weekday mismatch");
   AST_EVERY_SEC: assert property (i_tick_update && (&{st_r.alm1[3][7], st_r.alm1[2][7], // RL10
      st_r.alm1[1][7], st_r.alm1[0][7]}) |=> st_r.flags[0]) else $error("all-masked alarm one missed");
   AST_A2_ZERO_SEC: assert property (i_tick_update && i_time.sec[6:0] != RTCAM_ZERO_SECONDS // RL11
      && !st_r.flags[1] |=> !st_r.flags[1]) else $error("alarm two fired off the zero second");
   AST_FLAG_NEEDS_TICK: assert property ($rose(st_r.flags[0]) |-> $past(i_tick_update)) // RL9
      else $error("flag rose without an update");
   AST_FLAG_HOLD: assert property (st_r.flags[0] && !(i_reg.wr && i_reg.addr == RTCAM_OFS_STATUS) // RL15
      |=> st_r.flags[0]) else $error("flag dropped without a clearing write");
   AST_IRQ_ASSERTS: assert property (st_r.flags[0] && st_r.control[0] && st_r.control[2] // RL8
      |=> !o_irq_or_square_wave_out_n) else $error("enabled alarm not driving interrupt");
   AST_IRQ_RELEASE: assert property (!st_r.control[2] ##1 1 |-> o_irq_or_square_wave_out_n) // RL8
      else $error("interrupt driven in square-wave mode");
   AST_CLEAR_RELEASE: assert property (i_reg.wr && i_reg.addr == RTCAM_OFS_STATUS && // RL15
      i_reg.wdata[1:0] == 2'h0 && !i_tick_update ##1 !i_tick_update |=> o_irq_or_square_wave_out_n)
      else $error("interrupt stuck after flags cleared");

endmodule // rtcam_alarm

`default_nettype wire

// ---- rtcam_host.sv ----
/*
 * host model on the far side of the register port: byte writes and reads.
 * assumes each request is taken at a single rising edge and read data follows a cycle later.
 */
`timescale 1ns/100ps
`default_nettype none

module rtcam_host
   import rtcam_pkg::*;
(
   // clock and read data
   input  wire logic       i_sys_clk,
   input  wire logic [7:0] i_rdata,
   // request
   output var rtcam_regacc_type o_reg
);
   // ---------------------------------------------------------------
   // bus cycles
   // ---------------------------------------------------------------
   initial o_reg = '0;

   // released address and data show the inverse so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      #1 o_reg = {2'h2, a, d};
      @(posedge i_sys_clk);
      #1 o_reg = {2'h0, ~a, ~d};
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_sys_clk);
      #1 o_reg = {2'h1, a, 8'h00};
      @(posedge i_sys_clk);
      #1 d = i_rdata;
      o_reg = {2'h0, ~a, 8'hFF};
   endtask
endmodule // rtcam_host

`default_nettype wire

// ---- testbench.sv ----
/*
 * self-checking bench of the dual alarm-match block with random alarms.
 * assumes one-cycle register strobes and a one-cycle tick with the new time already applied.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench
   import rtcam_pkg::*;
;
   logic             i_sys_clk = 1'b0;
   logic             i_nrst    = 1'b0;
   logic             tick      = 1'b0;
   rtcam_time_type   tm        = '0;
   rtcam_regacc_type regb;
   logic [7:0]       rdata;
   logic [1:0]       flags;
   logic             irq_n;
   int               error_cnt  = 0;
   int               n_compared = 0;

   always #10 i_sys_clk = ~i_sys_clk;

   rtcam_host rtcam_host_i (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_reg(regb));

   rtcam_alarm rtcam_alarm_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_reg(regb), .i_tick_update(tick),
      .i_time(tm), .o_reg_rdata(rdata), .o_alarm_flags(flags), .o_irq_or_square_wave_out_n(irq_n));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rtcam_host_i.rd(a, d);
      chk("rdata", e, d);
   endtask

   task automatic tick_at(input rtcam_time_type t);
      @(posedge i_sys_clk);
      #1 tm = t;
      tick = 1'b1;
      @(posedge i_sys_clk);
      #1 tick = 1'b0;
   endtask

   function automatic logic [7:0] bcd(input int v);
      return 8'((v / 10) * 16 + v % 10);
   endfunction

   // per-field equality: {daydate, hour, minute, second}
   function automatic logic [3:0] hit(input rtcam_time_type t, input logic [7:0] s, m, h, dd, input logic dy);
      return {(dy ? t.day[5:0] : t.date[5:0]) == dd[5:0], t.hour[6:0] == h[6:0],
              t.min[6:0] == m[6:0], t.sec[6:0] == s[6:0]};
   endfunction

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      logic [7:0]     s, m, h, dd;
      logic [7:0]     av [7];
      logic [3:0]     m1, hv;
      logic [2:0]     m2, ctl;
      logic [1:0]     v;
      logic           dy, e1, e2;
      rtcam_time_type t;
      void'($urandom(32'hBFFC38A2));
      repeat (16) @(posedge i_sys_clk);
      #1 i_nrst = 1'b1;
      rdchk(RTCAM_OFS_CONTROL, RTCAM_CONTROL_RST);
      rdchk(RTCAM_OFS_STATUS, 8'h00);
      for (int a = 7; a <= 13; a++) rdchk(8'(a), RTCAM_ALARM_RST);
      rtcam_host_i.wr(8'h10, 8'h5A);
      rdchk(8'h10, RTCAM_UNMAPPED_RD);
      $display("test reset values done");
      for (int n = 0; n < 80; n++)
      begin
         s  = bcd($urandom % 60);
         m  = bcd($urandom % 60);
         h  = bcd($urandom % 24);
         dy = 1'($urandom);
         dd = dy ? bcd(1 + $urandom % 7) : bcd(1 + $urandom % 31);
         // only the listed mask patterns are ever programmed
         m1 = 4'hF << ($urandom % 5);
         m2 = 3'h7 << ($urandom % 4);
         av = '{{m1[0], s[6:0]}, {m1[1], m[6:0]}, {m1[2], h[6:0]}, {m1[3], dy, dd[5:0]},
                {m2[0], m[6:0]}, {m2[1], h[6:0]}, {m2[2], dy, dd[5:0]}};
         for (int i = 0; i < 7; i++) rtcam_host_i.wr(RTCAM_OFS_ALM1_SEC + 8'(i), av[i]);
         for (int i = 0; i < 7; i++) rdchk(RTCAM_OFS_ALM1_SEC + 8'(i), av[i]);
         ctl = 3'($urandom);
         rtcam_host_i.wr(RTCAM_OFS_CONTROL, {5'h03, ctl});
         rdchk(RTCAM_OFS_CONTROL, {5'h03, ctl});
         chk("flags", 8'h00, {6'h00, flags});
         t.sec  = ($urandom % 3 == 0) ? 8'h00 : (($urandom % 2) ? s : bcd($urandom % 60));
         t.min  = ($urandom % 4) ? m : bcd($urandom % 60);
         t.hour = ($urandom % 4) ? h : bcd($urandom % 24);
         t.day  = (dy && ($urandom % 4)) ? dd : bcd(1 + $urandom % 7);
         t.date = (!dy && ($urandom % 4)) ? dd : bcd(1 + $urandom % 31);
         hv = hit(t, s, m, h, dd, dy);
         e1 = &(hv | m1);
         e2 = &(hv[3:1] | m2) & (t.sec[6:0] == RTCAM_ZERO_SECONDS);
         tick_at(t);
         chk("flags", {6'h00, e2, e1}, {6'h00, flags});
         @(posedge i_sys_clk);
         #1 chk("irq_n", {7'h00, ~(ctl[2] & ((e1 & ctl[0]) | (e2 & ctl[1])))}, {7'h00, irq_n});
         v = 2'($urandom);
         rtcam_host_i.wr(RTCAM_OFS_STATUS, {6'h00, v});
         chk("flags", {6'h00, {e2, e1} & v}, {6'h00, flags});
         rdchk(RTCAM_OFS_STATUS, {6'h00, {e2, e1} & v});
         rtcam_host_i.wr(RTCAM_OFS_STATUS, 8'h00);
         @(posedge i_sys_clk);
         #1 chk("irq_n", 8'h01, {7'h00, irq_n});
      end
      $display("test random alarms done");
      finish_test();
   end

   // hang guard well above the test length
   initial
   begin
      #1000000;
      error_cnt++;
      finish_test();
   end
endmodule // testbench

`default_nettype wire
